/* File: integrity_pkg.sv */
// constants and types shared by the system integrity reset/flag block
package integrity_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00; // control/status
  localparam logic [7:0] ADDR_PLL_TEST = 8'h01; // pll test control

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_FAST_LOCK = 7;
  localparam int BIT_TRIM_HI = 6;
  localparam int BIT_TRIM_LO = 5;
  localparam int BIT_WDG_FLAG = 4;
  localparam int BIT_PLL_LOCK = 3;
  localparam int BIT_SUP_FLAG = 2;
  localparam int BIT_WARN_FLAG = 1;
  localparam int BIT_WARN_IE = 0;
  localparam int BIT_HALF_SEL = 7;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [1:0] RST_TRIM_LOW = 2'h3;
  localparam logic RST_HALF_SEL = 1'b0;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLOCK_MHZ = 40;
  localparam int HALF_DELAY_NS = 250; // half select latency
  localparam int HALF_DELAY_CYC = (HALF_DELAY_NS * CLOCK_MHZ + 999) / 1000;
  localparam int WDG_PULSE_NS = 1000; // plain default, least time
  localparam int WDG_PULSE_CYC = (WDG_PULSE_NS * CLOCK_MHZ + 999) / 1000;

  // threshold levels of the supply detector
  typedef enum logic [1:0] {
    LVL_LOW = 2'h1,
    LVL_MED = 2'h2,
    LVL_HIGH = 2'h3
  } level_t;

endpackage : integrity_pkg

/* File: integrity_reset_flags.sv */
// system integrity block: reset pin control, reset flags, warning irq
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module integrity_reset_flags #(
  parameter int WDG_CYC = integrity_pkg::WDG_PULSE_CYC,
  parameter int HALF_CYC = integrity_pkg::HALF_DELAY_CYC
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic OPT_DETECT_EN,
  input wire logic [1:0] OPT_LEVEL,
  input wire logic SUPPLY_LOW,
  input wire logic WARN_LOW,
  input wire logic FAST_PLL_LOCKED,
  input wire logic PLL_LOCKED,
  input wire logic WDG_UNDERFLOW,
  input wire logic IRQ_ACK,
  input wire logic WAIT_MODE,
  input wire logic HALT_MODE,
  input wire logic RST_PIN_I,
  output logic RST_PIN_O,
  output logic RST_PIN_OE_N,
  output logic SYS_RST_N,
  output logic [1:0] LEVEL_SEL,
  output logic DETECT_EN,
  output logic WARN_IRQ,
  output logic WAKE_REQ,
  output logic [1:0] TRIM_LOW,
  output logic PLL_HALF
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------

  // clip an int count into a counter width
  function automatic logic [7:0] cnt8(input int v);
    cnt8 = v[7:0];
  endfunction : cnt8

  // decode a register hit from address and strobe
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] r,
                               input logic s);
    hit = s && (a == r);
  endfunction : hit

  // ------------------------------------------------------------
  // input synchroniser
  // ------------------------------------------------------------
  // all pins and analog outputs are foreign to CLOCK
  logic [7:0] sync1_r; // first stage, read only by stage two
  logic [7:0] sync2_r; // second stage, safe to use
  wire logic [7:0] pins = {RST_PIN_I, OPT_DETECT_EN, OPT_LEVEL,
                           SUPPLY_LOW, WARN_LOW, FAST_PLL_LOCKED,
                           PLL_LOCKED};

  // two flops per line, no logic in between
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      sync1_r <= 8'h80;
      sync2_r <= 8'h80;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
    end
  end

  wire logic pin_high_s = sync2_r[7]; // pin level seen
  wire logic det_en_s = sync2_r[6]; // option: detector on
  wire logic [1:0] level_s = sync2_r[5:4]; // option: threshold
  wire logic sup_low_s = sync2_r[3]; // supply comparator
  wire logic warn_low_s = sync2_r[2]; // warning comparator
  wire logic fast_lock_s = sync2_r[1];
  wire logic pll_lock_s = sync2_r[0];

  // ------------------------------------------------------------
  // supply detector and option decode
  // ------------------------------------------------------------
  // hysteresis lives in the comparator; digital side just
  // holds reset while the comparator says low
  wire logic sup_reset = det_en_s && sup_low_s;

  // an unused option code falls back to the low level
  wire logic [1:0] level_nxt = (level_s == 2'h0) ?
                               integrity_pkg::LVL_LOW : level_s;

  logic [1:0] level_r; // threshold select to comparator
  logic det_en_r; // detector enable to comparator

  // option decode held in flops for clean outputs
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      level_r <= integrity_pkg::LVL_LOW;
      det_en_r <= 1'b0;
    end else begin
      level_r <= level_nxt;
      det_en_r <= det_en_s;
    end
  end

  // ------------------------------------------------------------
  // watchdog pulse stretcher
  // ------------------------------------------------------------
  logic [7:0] wdg_cnt_r; // remaining low cycles
  wire logic [7:0] wdg_cnt_nxt = WDG_UNDERFLOW ? cnt8(WDG_CYC) :
                                 (wdg_cnt_r != 8'h00) ?
                                 wdg_cnt_r - 8'h01 : 8'h00;

  // restart on each underflow so the pulse is never short
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      wdg_cnt_r <= 8'h00;
    end else begin
      wdg_cnt_r <= wdg_cnt_nxt;
    end
  end

  wire logic wdg_reset = (wdg_cnt_r != 8'h00);

  // ------------------------------------------------------------
  // reset pin and internal reset
  // ------------------------------------------------------------
  wire logic drive_low = sup_reset || wdg_reset;
  // own drive also reads back low, which only lengthens reset
  wire logic any_reset = drive_low || !pin_high_s;

  logic pin_oe_n_r; // low while pulling the pin
  logic sys_rst_n_r; // internal reset, low active

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      pin_oe_n_r <= 1'b0;
      sys_rst_n_r <= 1'b0;
    end else begin
      pin_oe_n_r <= !drive_low;
      sys_rst_n_r <= !any_reset;
    end
  end

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  // halt freezes software access to the status register
  wire logic st_rd = hit(ADDR, integrity_pkg::ADDR_STATUS, RD) &&
                     !HALT_MODE;
  wire logic st_wr = hit(ADDR, integrity_pkg::ADDR_STATUS, WR) &&
                     !HALT_MODE;
  wire logic pt_rd = hit(ADDR, integrity_pkg::ADDR_PLL_TEST, RD);
  wire logic pt_wr = hit(ADDR, integrity_pkg::ADDR_PLL_TEST, WR);

  // ------------------------------------------------------------
  // reset source flags
  // ------------------------------------------------------------
  logic wdg_flag_r; // last reset came from the watchdog
  logic sup_flag_r; // last reset came from the supply

  // supply reset clears watchdog flag and wins over its set
  wire logic wdg_flag_nxt =
    sup_reset ? 1'b0 :
    WDG_UNDERFLOW ? 1'b1 : // set beats software clear
    (st_rd || (st_wr && !WDATA[integrity_pkg::BIT_WDG_FLAG])) ?
    1'b0 : wdg_flag_r;

  // only a read clears; pin and watchdog resets leave it alone
  wire logic sup_flag_nxt =
    sup_reset ? 1'b1 :
    st_rd ? 1'b0 : sup_flag_r;

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      wdg_flag_r <= 1'b0;
      sup_flag_r <= 1'b0;
    end else begin
      wdg_flag_r <= wdg_flag_nxt;
      sup_flag_r <= sup_flag_nxt;
    end
  end

  // ------------------------------------------------------------
  // warning detector, flag view and interrupt
  // ------------------------------------------------------------
  wire logic warn_live = det_en_s && warn_low_s;
  logic warn_prev_r; // live value one cycle back
  logic warn_view_r; // value shown in the register
  logic warn_ie_r; // interrupt enable
  logic pend_r; // pending warning interrupt
  logic wake_r; // wake request for wait mode

  wire logic warn_rise = warn_live && !warn_prev_r;
  // set wins over the acknowledge in the same cycle
  wire logic pend_nxt = (warn_rise && warn_ie_r) ? 1'b1 :
                        IRQ_ACK ? 1'b0 : pend_r;
  // halt never wakes from this source; wait does
  wire logic wake_nxt = pend_nxt && WAIT_MODE && !HALT_MODE;
  wire logic ie_nxt = st_wr ? WDATA[integrity_pkg::BIT_WARN_IE] :
                      warn_ie_r;

  // detector stays active in halt; only the view freezes
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      warn_prev_r <= 1'b0;
      warn_view_r <= 1'b0;
      warn_ie_r <= 1'b0;
      pend_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      warn_prev_r <= warn_live;
      warn_view_r <= HALT_MODE ? warn_view_r : warn_live;
      warn_ie_r <= ie_nxt;
      pend_r <= pend_nxt;
      wake_r <= wake_nxt;
    end
  end

  // ------------------------------------------------------------
  // trim bits and lock view
  // ------------------------------------------------------------
  logic [1:0] trim_r; // low oscillator trim bits
  logic fast_lock_r; // fast pll lock, hardware only
  logic pll_lock_r; // main pll lock, hardware only

  // software calibrates after reset; block only stores it
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      trim_r <= integrity_pkg::RST_TRIM_LOW;
      fast_lock_r <= 1'b0;
      pll_lock_r <= 1'b0;
    end else begin
      if (st_wr) begin
        trim_r <= WDATA[integrity_pkg::BIT_TRIM_HI:
                        integrity_pkg::BIT_TRIM_LO];
      end
      fast_lock_r <= HALT_MODE ? fast_lock_r : fast_lock_s;
      pll_lock_r <= HALT_MODE ? pll_lock_r : pll_lock_s;
    end
  end

  // ------------------------------------------------------------
  // pll half select with delayed effect
  // ------------------------------------------------------------
  logic half_reg_r; // value software wrote
  logic half_out_r; // value applied to the divider
  logic [7:0] half_cnt_r; // cycles until it applies

  // reserved bits are not stored, so they always read zero
  wire logic half_wr_val = WDATA[integrity_pkg::BIT_HALF_SEL];
  wire logic [7:0] half_cnt_nxt = pt_wr ? cnt8(HALF_CYC) :
                                  (half_cnt_r != 8'h00) ?
                                  half_cnt_r - 8'h01 : 8'h00;
  wire logic half_apply = (half_cnt_r == 8'h01);

  // a second write restarts the delay with the new value
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      half_reg_r <= integrity_pkg::RST_HALF_SEL;
      half_out_r <= integrity_pkg::RST_HALF_SEL;
      half_cnt_r <= 8'h00;
    end else begin
      if (pt_wr) begin
        half_reg_r <= half_wr_val;
      end
      half_cnt_r <= half_cnt_nxt;
      if (half_apply) begin
        half_out_r <= half_reg_r;
      end
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  wire logic [7:0] status_word = {fast_lock_r, trim_r, wdg_flag_r,
                                  pll_lock_r, sup_flag_r,
                                  warn_view_r, warn_ie_r};
  wire logic [7:0] pll_word = {half_reg_r, 7'h00};
  wire logic [7:0] rd_word = st_rd ? status_word :
                             pt_rd ? pll_word : 8'h00;
  logic [7:0] rdata_r; // data for the cycle after a read

  // unmapped or idle cycles return zero
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rd_word;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  logic pin_o_r; // open drain only ever drives zero
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      pin_o_r <= 1'b0;
    end else begin
      pin_o_r <= 1'b0;
    end
  end

  assign RDATA = rdata_r;
  assign RST_PIN_O = pin_o_r;
  assign RST_PIN_OE_N = pin_oe_n_r;
  assign SYS_RST_N = sys_rst_n_r;
  assign LEVEL_SEL = level_r;
  assign DETECT_EN = det_en_r;
  assign WARN_IRQ = pend_r;
  assign WAKE_REQ = wake_r;
  assign TRIM_LOW = trim_r;
  assign PLL_HALF = half_out_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  sequence s_underflow;
    WDG_UNDERFLOW;
  endsequence

  sequence s_pin_held;
    !RST_PIN_OE_N [*8];
  endsequence

  a_supply_drives_pin: assert property (
    sup_reset |=> !RST_PIN_OE_N)
    else $error("pin not driven during supply reset");

  a_wdg_pulse_len: assert property (
    s_underflow |=> ##1 s_pin_held)
    else $error("watchdog pulse too short");

  a_detect_gates_reset: assert property (
    !det_en_s && !wdg_reset && !WDG_UNDERFLOW |=> RST_PIN_OE_N)
    else $error("pin driven with detector off");

  a_warn_gated: assert property (
    !det_en_s |=> !warn_prev_r)
    else $error("warning active with detector off");

  a_irq_on_rise: assert property (
    warn_rise && warn_ie_r |=> WARN_IRQ)
    else $error("warning interrupt not raised");

  a_irq_ack: assert property (
    IRQ_ACK && !(warn_rise && warn_ie_r) |=> !WARN_IRQ)
    else $error("pending warning not cleared");

  a_no_halt_wake: assert property (
    HALT_MODE |=> !WAKE_REQ)
    else $error("wake request raised in halt");

  a_wdg_flag_read: assert property (
    st_rd && !WDG_UNDERFLOW ##1 !WDG_UNDERFLOW && !st_wr
    |-> ##1 !status_word[integrity_pkg::BIT_WDG_FLAG])
    else $error("watchdog flag survived a read");

  a_sup_flag_kept: assert property (
    sup_flag_r && !st_rd && WDG_UNDERFLOW |=> sup_flag_r)
    else $error("supply flag lost on watchdog reset");

  a_half_delay: assert property (
    pt_wr ##1 !pt_wr [*8] ##1 !pt_wr |=> ##1 PLL_HALF == $past(half_reg_r))
    else $error("half select delay wrong");

  a_sys_reset_or: assert property (
    wdg_reset |=> !SYS_RST_N)
    else $error("internal reset missed watchdog");

endmodule : integrity_reset_flags

`default_nettype wire

/* File: reset_line_model.sv */
// model of the outside circuitry sharing the open-drain reset line
`timescale 1ns/100ps
`default_nettype none

module reset_line_model (
  input wire logic dev_o, // level the device drives, always low
  input wire logic dev_oe_n, // low while the device pulls the line
  input wire logic ext_pull, // outside circuitry pulls the line low
  output logic line // resolved level seen by every party
);
  // ------------------------------------------------------------
  // wired-and with a weak pull-up
  // ------------------------------------------------------------
  // nobody pulling leaves the pull-up level, never the last value
  assign line = ~((~dev_oe_n & ~dev_o) | ext_pull);
endmodule : reset_line_model

`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the integrity reset and flag block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %0t got %h want %h", $time, g, e); end end

module tb_top;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  localparam int WC = 8; // pulse assertion counts eight low cycles
  localparam int HC = 10; // half-select latency, 250 ns at 40 MHz
  localparam logic [7:0] ST = integrity_pkg::ADDR_STATUS;
  localparam logic [7:0] PT = integrity_pkg::ADDR_PLL_TEST;
  logic CLOCK = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0;
  logic OPT_DETECT_EN = 1'b0, SUPPLY_LOW = 1'b0, WARN_LOW = 1'b0;
  logic FAST_PLL_LOCKED = 1'b0, PLL_LOCKED = 1'b0, WDG_UNDERFLOW = 1'b0;
  logic IRQ_ACK = 1'b0, WAIT_MODE = 1'b0, HALT_MODE = 1'b0;
  logic ext_pull = 1'b0; // outside party pulling the reset line
  logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA, rv;
  logic [1:0] OPT_LEVEL = 2'h1, LEVEL_SEL, TRIM_LOW;
  logic RST_PIN_O, RST_PIN_OE_N, SYS_RST_N, DETECT_EN;
  logic WARN_IRQ, WAKE_REQ, PLL_HALF;
  wire RST_PIN_I; // resolved reset line
  int miscompares = 0, n_tests = 0, k;

  integrity_reset_flags #(.WDG_CYC(WC), .HALF_CYC(HC)) dut (.CLOCK, .NRST,
    .ADDR, .WDATA, .WR, .RD, .RDATA, .OPT_DETECT_EN, .OPT_LEVEL, .SUPPLY_LOW,
    .WARN_LOW, .FAST_PLL_LOCKED, .PLL_LOCKED, .WDG_UNDERFLOW, .IRQ_ACK,
    .WAIT_MODE, .HALT_MODE, .RST_PIN_I, .RST_PIN_O, .RST_PIN_OE_N, .SYS_RST_N,
    .LEVEL_SEL, .DETECT_EN, .WARN_IRQ, .WAKE_REQ, .TRIM_LOW, .PLL_HALF);

  reset_line_model line_m (.dev_o(RST_PIN_O), .dev_oe_n(RST_PIN_OE_N),
    .ext_pull(ext_pull), .line(RST_PIN_I));

  // ------------------------------------------------------------
  // clock and shared tasks
  // ------------------------------------------------------------
  // 25 ns period
  initial begin
    forever #12.5 CLOCK = ~CLOCK;
  end

  task automatic cyc(input int n); // settle just after the n-th edge
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1 rv = RDATA;
  endtask : rd

  task automatic pulse_wdg(); // one-cycle watchdog underflow
    @(posedge CLOCK);
    WDG_UNDERFLOW <= 1'b1;
    @(posedge CLOCK);
    WDG_UNDERFLOW <= 1'b0;
  endtask : pulse_wdg

  task automatic ack(); // cpu enters the warning routine
    @(posedge CLOCK);
    IRQ_ACK <= 1'b1;
    @(posedge CLOCK);
    IRQ_ACK <= 1'b0;
    cyc(1);
  endtask : ack

  task automatic final_report();
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset(); // values after power-on
    rd(ST);
    `CHK(rv, 8'h60)
    rd(PT);
    `CHK(rv, 8'h00)
    rd(8'h05); // unmapped place reads zero
    `CHK(rv, 8'h00)
    `CHK(TRIM_LOW, 2'h3)
    `CHK(DETECT_EN, 1'b0)
  endtask : t_reset

  task automatic t_levels(); // every option code, 0 falls back to low
    OPT_DETECT_EN <= 1'b1;
    for (int lv = 0; lv < 4; lv++) begin
      OPT_LEVEL <= 2'(lv);
      cyc(5);
      `CHK(LEVEL_SEL, (lv == 0) ? 2'h1 : 2'(lv))
    end
    `CHK(DETECT_EN, 1'b1)
  endtask : t_levels

  task automatic t_watchdog(); // pin pulse, flag set and both clears
    pulse_wdg();
    cyc(1);
    `CHK(RST_PIN_OE_N, 1'b0)
    `CHK(SYS_RST_N, 1'b0)
    k = 1;
    while (RST_PIN_OE_N === 1'b0 && k < 100) begin
      cyc(1);
      k++;
    end
    `CHK(k, WC + 1)
    cyc(8);
    rd(ST);
    `CHK({rv[4], rv[2]}, 2'b10)
    rd(ST);
    `CHK(rv[4], 1'b0)
    pulse_wdg();
    cyc(10);
    wr(ST, 8'h60); // zero in the flag bit clears it
    rd(ST);
    `CHK(rv[4], 1'b0)
  endtask : t_watchdog

  task automatic t_supply(); // supply reset, flag history, disabled case
    pulse_wdg();
    cyc(10);
    SUPPLY_LOW <= 1'b1;
    cyc(4);
    `CHK(RST_PIN_OE_N, 1'b0)
    `CHK(RST_PIN_O, 1'b0)
    cyc(10);
    `CHK(SYS_RST_N, 1'b0)
    SUPPLY_LOW <= 1'b0;
    cyc(12);
    rd(ST);
    `CHK({rv[4], rv[2]}, 2'b01)
    SUPPLY_LOW <= 1'b1;
    cyc(6);
    SUPPLY_LOW <= 1'b0;
    cyc(12);
    pulse_wdg(); // later watchdog reset keeps the supply record
    cyc(10);
    rd(ST);
    `CHK(rv[2], 1'b1)
    rd(ST);
    `CHK({rv[4], rv[2]}, 2'b00)
    OPT_DETECT_EN <= 1'b0;
    SUPPLY_LOW <= 1'b1;
    cyc(6);
    `CHK(RST_PIN_OE_N, 1'b1)
    SUPPLY_LOW <= 1'b0;
    OPT_DETECT_EN <= 1'b1;
    cyc(6);
  endtask : t_supply

  task automatic t_extpin(); // outside party pulls the shared line
    ext_pull <= 1'b1;
    cyc(5);
    `CHK(SYS_RST_N, 1'b0)
    ext_pull <= 1'b0;
    cyc(10);
    `CHK(SYS_RST_N, 1'b1)
    rd(ST);
    `CHK({rv[4], rv[2]}, 2'b00)
  endtask : t_extpin

  task automatic t_warn(); // warning flag, pending irq, wake, halt
    wr(ST, 8'h61);
    WARN_LOW <= 1'b1;
    cyc(5);
    `CHK(WARN_IRQ, 1'b1)
    rd(ST);
    `CHK(rv[1:0], 2'b11)
    ack();
    `CHK(WARN_IRQ, 1'b0)
    WARN_LOW <= 1'b0;
    cyc(5);
    rd(ST);
    `CHK(rv[1], 1'b0)
    WAIT_MODE <= 1'b1;
    WARN_LOW <= 1'b1;
    cyc(6);
    `CHK(WAKE_REQ, 1'b1)
    ack();
    WARN_LOW <= 1'b0;
    HALT_MODE <= 1'b1; // halt: no wake, register frozen
    cyc(5);
    WARN_LOW <= 1'b1;
    cyc(6);
    `CHK(WAKE_REQ, 1'b0)
    rd(ST);
    `CHK(rv, 8'h00)
    wr(ST, 8'h00);
    HALT_MODE <= 1'b0;
    WAIT_MODE <= 1'b0;
    ack();
    WARN_LOW <= 1'b0;
    cyc(5);
    rd(ST);
    `CHK({rv[6:5], rv[0]}, 3'b111)
    wr(ST, 8'h60); // enable off: no request
    WARN_LOW <= 1'b1;
    cyc(6);
    `CHK(WARN_IRQ, 1'b0)
    WARN_LOW <= 1'b0;
    OPT_DETECT_EN <= 1'b0; // detector off: no flag, no request
    wr(ST, 8'h61);
    cyc(5);
    WARN_LOW <= 1'b1;
    cyc(6);
    `CHK(WARN_IRQ, 1'b0)
    rd(ST);
    `CHK(rv[1], 1'b0)
    WARN_LOW <= 1'b0;
    OPT_DETECT_EN <= 1'b1;
  endtask : t_warn

  task automatic t_locks(); // lock flags follow hardware only
    FAST_PLL_LOCKED <= 1'b1;
    PLL_LOCKED <= 1'b1;
    cyc(5);
    wr(ST, 8'h20); // software trim after reset, lock bits written zero
    rd(ST);
    `CHK({rv[7], rv[3]}, 2'b11)
    `CHK(TRIM_LOW, 2'h1)
    FAST_PLL_LOCKED <= 1'b0;
    PLL_LOCKED <= 1'b0;
    cyc(5);
    rd(ST);
    `CHK({rv[7], rv[3]}, 2'b00)
  endtask : t_locks

  task automatic t_half(); // divide control, latency, reserved, reset
    wr(PT, 8'h80); // reserved bits always written zero
    cyc(HC - 2);
    `CHK(PLL_HALF, 1'b0)
    cyc(4);
    `CHK(PLL_HALF, 1'b1)
    rd(PT);
    `CHK(rv, 8'h80)
    wr(8'h07, 8'hff); // unmapped write is dropped
    rd(8'h07);
    `CHK(rv, 8'h00)
    wr(PT, 8'h00);
    cyc(HC + 2);
    `CHK(PLL_HALF, 1'b0)
    wr(PT, 8'h80);
    cyc(HC + 2);
    @(posedge CLOCK);
    NRST <= 1'b0; // second reset in mid-run
    cyc(4);
    NRST <= 1'b1;
    cyc(12);
    `CHK(PLL_HALF, 1'b0)
    `CHK(TRIM_LOW, 2'h3)
    rd(PT);
    `CHK(rv, 8'h00)
  endtask : t_half

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge CLOCK);
    NRST <= 1'b1;
    cyc(12); // synchronisers and pin release settle
    t_reset();
    t_levels();
    t_watchdog();
    t_supply();
    t_extpin();
    t_warn();
    t_locks();
    t_half();
    final_report();
  end

  // the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge CLOCK);
    miscompares++;
    final_report();
  end
endmodule : tb_top

`default_nettype wire
